// [sps_sram.sv]
// separate port burst sram core with read word fifo

`include "sps_consts.svh"

module sps_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,     // clock
  input  wire logic             nrst_i,    // async reset, low
  input  wire logic             in_valid_i, // push request
  output logic                  in_ready_o, // room for a word
  input  wire logic [WIDTH-1:0] in_data_i,  // pushed word
  output logic                  out_valid_o, // word available
  input  wire logic             out_ready_i, // pop request
  output logic      [WIDTH-1:0] out_data_o   // head word
);
  // count tracks occupancy so full and empty never alias
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
  logic [PW-1:0]    wp_reg;
  logic [PW-1:0]    rp_reg;
  logic [PW:0]      cnt_reg;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_reg != DEPTH[PW:0]);
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rp_reg];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end
endmodule : sps_fifo

module sps_sram #(
  parameter int STOP_LIMIT_CYC = `SPS_STOP_DEF_CYC
) (
  input  wire logic                    ref_clk_i,               // core clock 20 MHz
  input  wire logic                    nrst_i,                  // async reset, low
  input  wire logic                    k_i,                     // positive input clock
  input  wire logic                    k_n_i,                   // negative input clock
  input  wire logic [`SPS_ADDR_W-1:0]  addr_i,                  // shared burst address
  input  wire logic                    read_port_select_n_i,    // read select, low
  input  wire logic                    write_port_select_n_i,   // write select, low
  input  wire logic [`SPS_DATA_W-1:0]  d_i,                     // write data
  input  wire logic [`SPS_BYTES-1:0]   byte_write_select_n_i,   // byte selects, low
  input  wire logic                    loop_disable_n_i,        // loop off when low
  output logic      [`SPS_DATA_W-1:0]  q_o,                     // read data
  output logic                         q_oe_o,                  // read data drive enable
  output logic                         echo_clock_o,            // echo of k
  output logic                         echo_clock_n_o,          // echo of k_n
  output logic                         read_valid_flag_o,       // read data valid
  output logic                         dll_locked_o,            // loop locked
  output logic                         impedance_update_o       // impedance update pulse
);
  localparam int AW = `SPS_ADDR_W;
  localparam int DW = `SPS_DATA_W;
  localparam int BW = `SPS_BYTE_W;
  localparam int MW = AW + 2;
  // the stop limit never drops below the minimum clock-stop gap
  localparam int STOP_CYC = (STOP_LIMIT_CYC > `SPS_STOP_MIN_CYC) ?
                            STOP_LIMIT_CYC : `SPS_STOP_MIN_CYC;

  // input synchronisers, all pins share the same two stages
  logic [`SPS_SYNC_W-1:0] sync1_reg;
  logic [`SPS_SYNC_W-1:0] sync2_reg;
  logic                   k_d_reg;
  logic                   kn_d_reg;
  wire  [`SPS_SYNC_W-1:0] pins = {k_i, k_n_i, read_port_select_n_i, write_port_select_n_i,
                                  loop_disable_n_i, addr_i, d_i, byte_write_select_n_i};

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_reg <= {2'h0, 3'h7, {AW{1'b0}}, {DW{1'b0}}, 2'h3};
      sync2_reg <= {2'h0, 3'h7, {AW{1'b0}}, {DW{1'b0}}, 2'h3};
      k_d_reg   <= 1'b0;
      kn_d_reg  <= 1'b0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      k_d_reg   <= sync2_reg[43];
      kn_d_reg  <= sync2_reg[42];
    end
  end

  // edge flops compare against the second stage only
  wire          k_s      = sync2_reg[43];
  wire          kn_s     = sync2_reg[42];
  wire          rsel_n   = sync2_reg[41];
  wire          wsel_n   = sync2_reg[40];
  wire          dll_on   = sync2_reg[39];
  wire [AW-1:0] addr_s   = sync2_reg[38:20];
  wire [DW-1:0] d_s      = sync2_reg[19:2];
  wire [1:0]    bws_n_s  = sync2_reg[1:0];
  wire          k_rise   = k_s & ~k_d_reg;
  wire          kn_rise  = kn_s & ~kn_d_reg;
  wire          half     = k_rise | kn_rise;

  // port arbitration on K rises
  // a read grant blocks a write at the same K rise, so both selected alternate
  logic prev_rd_reg;
  logic prev_wr_reg;
  wire  rd_grant = k_rise & ~rsel_n & ~prev_rd_reg;
  wire  wr_grant = k_rise & ~wsel_n & ~prev_wr_reg & ~rd_grant;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_rd_reg <= 1'b0;
      prev_wr_reg <= 1'b0;
    end else if (k_rise) begin
      prev_rd_reg <= rd_grant;
      prev_wr_reg <= wr_grant;
    end
  end

  // write assembly: tokens age by one per half edge
  // words land at half edges two to five after the grant; commit follows the last
  logic [`SPS_WTOK_W-1:0] wtok_reg;
  logic [AW-1:0]          wr_addr_reg;
  logic [AW-1:0]          cmt_addr_reg;
  logic [DW-1:0]          wdat_reg [0:`SPS_BURST-1];
  logic [1:0]             wbws_reg [0:`SPS_BURST-1];
  logic                   commit_reg;
  wire  [`SPS_WTOK_W:0]   wsh      = {wtok_reg, wr_grant};
  wire  [3:0]             wslot    = wsh[`SPS_WR_FIRST+3:`SPS_WR_FIRST];
  wire                    wr_pend  = |wtok_reg;
  wire  [1:0]             widx     = wslot[1] ? 2'h1 : wslot[2] ? 2'h2 :
                                     wslot[3] ? 2'h3 : 2'h0;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wtok_reg     <= '0;
      wr_addr_reg  <= '0;
      cmt_addr_reg <= '0;
      commit_reg   <= 1'b0;
    end else begin
      commit_reg <= half & wslot[3];
      if (half) begin
        wtok_reg <= wsh[`SPS_WTOK_W-1:0];
      end
      if (wr_grant) begin
        wr_addr_reg <= addr_s;
      end
      if (half && wslot[0]) begin
        cmt_addr_reg <= wr_addr_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (half && (|wslot)) begin
      wdat_reg[widx] <= d_s;
      wbws_reg[widx] <= bws_n_s;
    end
  end

  // array: one word per burst beat, beat index in the low bits
  // unwritten words read back as unknowns
  logic [DW-1:0] mem_reg [0:(2**MW)-1];

  always_ff @(posedge ref_clk_i) begin
    if (commit_reg) begin
      for (int i = 0; i < `SPS_BURST; i++) begin
        if (!wbws_reg[i][0]) begin
          mem_reg[{cmt_addr_reg, i[1:0]}][BW-1:0] <= wdat_reg[i][BW-1:0];
        end
        if (!wbws_reg[i][1]) begin
          mem_reg[{cmt_addr_reg, i[1:0]}][DW-1:BW] <= wdat_reg[i][DW-1:BW];
        end
      end
    end
  end

  // read request queue, two deep; wait marks a write still assembling
  // a new grant's wait bit is written after the commit clear, so the set wins
  logic [AW-1:0] rq_addr_reg [0:1];
  logic [1:0]    rq_wait_reg;
  logic [1:0]    rq_cnt_reg;
  logic [1:0]    fidx_reg;
  sps_pkg::sps_fetch_t fstate_reg;
  logic          f_ready;
  wire           f_push   = (fstate_reg == sps_pkg::sps_f_run) & ~rq_wait_reg[0];
  wire           f_last   = f_push & f_ready & (fidx_reg == 2'h3);
  wire [DW-1:0]  f_data   = mem_reg[{rq_addr_reg[0], fidx_reg}];
  wire           q_pop    = f_last;
  wire [1:0]     slot_in  = q_pop ? rq_cnt_reg - 2'h1 : rq_cnt_reg;
  wire [1:0]     wait_sh  = q_pop ? {1'b0, rq_wait_reg[1]} : rq_wait_reg;
  wire [1:0]     wait_clr = commit_reg ? 2'h0 : wait_sh;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rq_addr_reg[0] <= '0;
      rq_addr_reg[1] <= '0;
      rq_wait_reg    <= 2'h0;
      rq_cnt_reg     <= 2'h0;
    end else begin
      if (q_pop) begin
        rq_addr_reg[0] <= rq_addr_reg[1];
      end
      rq_wait_reg <= wait_clr;
      if (rd_grant) begin
        rq_addr_reg[slot_in[0]] <= addr_s;
        rq_wait_reg[slot_in[0]] <= wr_pend;
      end
      rq_cnt_reg <= slot_in + {1'b0, rd_grant};
    end
  end

  // fetch pauses while the word buffer is full and resumes as the pins drain it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fstate_reg <= sps_pkg::sps_f_idle;
      fidx_reg   <= 2'h0;
    end else begin
      unique case (fstate_reg)
        sps_pkg::sps_f_idle: begin
          fidx_reg <= 2'h0;
          if (rq_cnt_reg != 2'h0) begin
            fstate_reg <= sps_pkg::sps_f_run;
          end
        end
        sps_pkg::sps_f_run: begin
          if (f_push && f_ready) begin
            fidx_reg <= fidx_reg + 2'h1;
          end
          if (f_last) begin
            fstate_reg <= sps_pkg::sps_f_idle;
          end
        end
      endcase
    end
  end

  // read word buffer between array and output pins
  // legacy mode taps the token chain three half edges earlier
  logic          o_valid;
  logic [DW-1:0] o_data;
  logic [`SPS_RTOK_W-1:0] rtok_reg;
  wire  [`SPS_RTOK_W:0]   rsh    = {rtok_reg, rd_grant};
  wire  [3:0]    emit_dll = rsh[`SPS_RD_FIRST_DLL+3:`SPS_RD_FIRST_DLL];
  wire  [3:0]    emit_off = rsh[`SPS_RD_FIRST_OFF+3:`SPS_RD_FIRST_OFF];
  wire           emit_any = dll_on ? |emit_dll : |emit_off;
  wire           vld_any  = dll_on ? (|emit_dll | rsh[`SPS_RD_FIRST_DLL-1]) :
                                     (|emit_off | rsh[`SPS_RD_FIRST_OFF-1]);
  wire           emit     = half & emit_any;

  sps_fifo #(
    .WIDTH (DW),
    .DEPTH (`SPS_FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (f_push),
    .in_ready_o  (f_ready),
    .in_data_i   (f_data),
    .out_valid_o (o_valid),
    .out_ready_i (emit),
    .out_data_o  (o_data)
  );

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rtok_reg          <= '0;
      q_o               <= '0;
      q_oe_o            <= 1'b0;
      read_valid_flag_o <= 1'b0;
    end else if (half) begin
      rtok_reg          <= rsh[`SPS_RTOK_W-1:0];
      q_oe_o            <= emit_any;
      read_valid_flag_o <= vld_any;
      if (emit_any) begin
        // a dry buffer at a beat shows zero rather than stale data
        q_o <= o_valid ? o_data : '0;
      end
    end
  end

  // echo clocks, impedance update and loop lock
  logic [9:0]  zq_cnt_reg;
  logic [11:0] lock_cnt_reg;
  logic [7:0]  idle_cnt_reg;
  wire         stopped   = (idle_cnt_reg >= STOP_CYC[7:0]);
  wire         lock_done = (lock_cnt_reg == 12'(`SPS_LOCK_CYC));

  // echo clocks are plain delayed copies of the synchronised input clocks
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      echo_clock_o   <= 1'b0;
      echo_clock_n_o <= 1'b0;
    end else begin
      echo_clock_o   <= k_s;
      echo_clock_n_o <= kn_s;
    end
  end

  // impedance update counts K rises from reset; the pulse lasts one ref cycle
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zq_cnt_reg         <= '0;
      impedance_update_o <= 1'b0;
    end else begin
      impedance_update_o <= k_rise & (zq_cnt_reg == 10'(`SPS_ZQ_CYC - 1));
      if (k_rise) begin
        zq_cnt_reg <= zq_cnt_reg + 10'h1;
      end
    end
  end

  // stop detector: no K rise for the stop limit drops the lock
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_reg <= '0;
      lock_cnt_reg <= '0;
      dll_locked_o <= 1'b0;
    end else begin
      if (k_rise) begin
        idle_cnt_reg <= '0;
      end else if (!stopped) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h1;
      end
      if (!dll_on || stopped) begin
        lock_cnt_reg <= '0;
      end else if (k_rise && !lock_done) begin
        lock_cnt_reg <= lock_cnt_reg + 12'h1;
      end
      dll_locked_o <= dll_on & lock_done & ~stopped;
    end
  end
endmodule : sps_sram

// [sps_consts.svh]
// constants of the separate port burst sram
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH
`define SPS_DATA_W       18
`define SPS_BYTE_W       9
`define SPS_BYTES        2
`define SPS_ADDR_W       19
`define SPS_BURST        4
`define SPS_SYNC_W       44
`define SPS_RTOK_W       8
`define SPS_WTOK_W       5
`define SPS_RD_FIRST_DLL 5
`define SPS_RD_FIRST_OFF 2
`define SPS_WR_FIRST     2
`define SPS_FIFO_DEPTH   4
`define SPS_LOCK_CYC     2048
`define SPS_ZQ_CYC       1024
`define SPS_REF_NS       50
`define SPS_STOP_NS      30
`define SPS_STOP_MIN_CYC ((`SPS_STOP_NS + `SPS_REF_NS - 1) / `SPS_REF_NS)
`define SPS_STOP_DEF_CYC 16
`endif

// [sps_pkg.sv]
// types of the separate port burst sram
package sps_pkg;
  typedef enum logic {
    sps_f_idle,
    sps_f_run
  } sps_fetch_t;
endpackage : sps_pkg

// [sps_sram_chk.sv]
// port checker of the burst sram
`include "sps_consts.svh"
module sps_sram_chk #(
  parameter int STOP_LIMIT_CYC = `SPS_STOP_DEF_CYC
) (
  input wire logic                   ref_clk_i,          // core clock
  input wire logic                   nrst_i,             // async reset, low
  input wire logic                   k_i,                // positive input clock
  input wire logic                   k_n_i,              // negative input clock
  input wire logic                   echo_clock_n_o,     // echo of k_n
  input wire logic                   loop_disable_n_i,   // loop off when low
  input wire logic [`SPS_DATA_W-1:0] q_o,                // read data
  input wire logic                   q_oe_o,             // read drive enable
  input wire logic                   echo_clock_o,       // echo of k
  input wire logic                   read_valid_flag_o,  // read valid
  input wire logic                   dll_locked_o,       // loop locked
  input wire logic                   impedance_update_o  // impedance pulse
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [7:0] still_reg;
  // ref cycles since k last moved, saturating
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) still_reg <= 8'h00;
    else if ($changed(k_i)) still_reg <= 8'h00;
    else if (still_reg != 8'hff) still_reg <= still_reg + 8'h01;
  end
  a_reset_idle: assert property ($rose(nrst_i) |-> !q_oe_o && !read_valid_flag_o)
    else $error("read outputs active after reset");
  a_valid_leads: assert property ($rose(q_oe_o) |-> $past(read_valid_flag_o, 3))
    else $error("valid flag not ahead of data");
  a_burst_len: assert property ($rose(q_oe_o) |-> q_oe_o [*8] ##1 q_oe_o [*7])
    else $error("read burst shorter than four words");
  a_drop_together: assert property ($fell(q_oe_o) |-> !read_valid_flag_o)
    else $error("valid flag outlives data drive");
  a_word_steps: assert property ($changed(q_o) |=> $stable(q_o) [*3])
    else $error("read data changed inside a half cycle");
  a_echo_rise: assert property ($rose(k_i) |-> ##[2:4] echo_clock_o)
    else $error("echo clock missed a rise");
  a_echo_fall: assert property ($fell(k_i) |-> ##[2:4] !echo_clock_o)
    else $error("echo clock missed a fall");
  a_echo_n_rise: assert property ($rose(k_n_i) |-> ##[2:4] echo_clock_n_o)
    else $error("negative echo clock missed a rise");
  a_zq_pulse: assert property (impedance_update_o |=> !impedance_update_o [*8])
    else $error("impedance update pulses too close");
  a_legacy_unlock: assert property (!loop_disable_n_i [*6] |-> !dll_locked_o)
    else $error("lock held with loop disabled");
  a_stop_unlock: assert property (still_reg > STOP_LIMIT_CYC + 6 |-> !dll_locked_o)
    else $error("lock held with k stopped");
endmodule : sps_sram_chk

bind sps_sram sps_sram_chk #(.STOP_LIMIT_CYC(STOP_LIMIT_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .k_i(k_i), .loop_disable_n_i(loop_disable_n_i),
  .k_n_i(k_n_i), .echo_clock_n_o(echo_clock_n_o),
  .q_o(q_o), .q_oe_o(q_oe_o), .echo_clock_o(echo_clock_o),
  .read_valid_flag_o(read_valid_flag_o), .dll_locked_o(dll_locked_o),
  .impedance_update_o(impedance_update_o));

// [sps_ctl_model.sv]
// memory controller model driving the burst sram pins
module sps_ctl_model (
  output logic        k_o,      // positive input clock
  output logic        k_n_o,    // negative input clock
  output logic [18:0] addr_o,   // burst address
  output logic        rd_n_o,   // read select, low
  output logic        wr_n_o,   // write select, low
  output logic [17:0] d_o,      // write data
  output logic [1:0]  bws_n_o   // byte selects, low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] beats[$];
  int          hc = 0;
  initial begin
    {k_o, k_n_o, rd_n_o, wr_n_o, bws_n_o} = 6'h0f;
    addr_o = '0;
    d_o = '0;
  end
  // each half edge carries the next queued beat, else a changing idle word
  task automatic next_beat();
    if (beats.size() != 0) {bws_n_o, d_o} = beats.pop_front();
    else begin
      bws_n_o = 2'b11;
      d_o = ~d_o;
    end
  endtask : next_beat
  // one k period, request held across its k rise
  task automatic kcyc(input logic rn, input logic wn, input logic [18:0] a,
                      input logic wd, input logic [71:0] dw, input logic [7:0] bw);
    #100;
    rd_n_o = rn;
    wr_n_o = wn;
    addr_o = a;
    next_beat();
    #100;
    k_o = 1'b1;
    k_n_o = 1'b0;
    hc++;
    if (wd) begin
      if (beats.size() == 0) beats.push_back({2'b11, ~d_o});
      for (int i = 0; i < 4; i++) beats.push_back({bw[2*i+:2], dw[18*i+:18]});
    end
    #100;
    next_beat();
    #100;
    k_o = 1'b0;
    k_n_o = 1'b1;
    hc++;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = ~a;
  endtask : kcyc
endmodule : sps_ctl_model

// [testbench.sv]
// self-checking bench of the burst sram
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [71:0] w_a = {18'h3a5c1, 18'h12345, 18'h0f0f0, 18'h2c3d4};
  localparam logic [71:0] w_b = {18'h1b2e7, 18'h30a0f, 18'h2468a, 18'h15555};
  localparam logic [71:0] w_c = {18'h0c0de, 18'h3ffff, 18'h00001, 18'h2aaaa};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        loop_n = 1'b1;
  logic        k, kn, rd_n, wr_n, oe, ec, vf, lk, zu;
  logic [18:0] addr;
  logic [17:0] d, q;
  logic [1:0]  bw_n;
  logic [17:0] rq[$];
  int          hq[$];
  int          errors = 0, samples_checked = 0, zc = 0, h0;
  always #25 clk = ~clk;
  sps_ctl_model mc (.k_o(k), .k_n_o(kn), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .d_o(d), .bws_n_o(bw_n));
  sps_sram #(.STOP_LIMIT_CYC(12)) DUT (.ref_clk_i(clk), .nrst_i(rst_n), .k_i(k), .k_n_i(kn),
    .addr_i(addr), .read_port_select_n_i(rd_n), .write_port_select_n_i(wr_n), .d_i(d),
    .byte_write_select_n_i(bw_n), .loop_disable_n_i(loop_n), .q_o(q), .q_oe_o(oe),
    .echo_clock_o(ec), .echo_clock_n_o(), .read_valid_flag_o(vf), .dll_locked_o(lk),
    .impedance_update_o(zu));
  // word of the previous half edge, taken mid-way through the current one
  always @(posedge k or posedge kn) begin
    #100;
    if (oe === 1'b1) begin
      rq.push_back(q);
      hq.push_back(mc.hc - 1);
    end
  end
  always @(negedge clk) if (zu === 1'b1) zc++;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] n, logic [7:0] b);
    for (int i = 0; i < 8; i++) merge[9*i+:9] = b[i] ? o[9*i+:9] : n[9*i+:9];
  endfunction : merge
  task automatic idle(input int n);
    repeat (n) mc.kcyc(1'b1, 1'b1, '0, 1'b0, '0, '0);
  endtask : idle
  task automatic rd(input logic [18:0] a, output int h);
    mc.kcyc(1'b0, 1'b1, a, 1'b0, '0, '0);
    h = mc.hc - 1;
  endtask : rd
  task automatic take(input int h, input int lat, input logic [71:0] w);
    if (rq.size() < 4) begin
      chk("burst count", rq.size(), 4);
      return;
    end
    chk("first word time", hq[0], h + lat);
    for (int i = 0; i < 4; i++) begin
      chk("burst word", rq.pop_front(), w[18*i+:18]);
      void'(hq.pop_front());
    end
  endtask : take
  task automatic s_lock();
    chk("drive after reset", oe, 0);
    for (int i = 1; i <= 2050; i++) begin
      idle(1);
      if (i == 2040) chk("early lock", lk, 0);
    end
    chk("lock", lk, 1);
    chk("impedance pulses", zc, 2);
    #1000;
    chk("lock after stop", lk, 0);
  endtask : s_lock
  task automatic s_rw();
    mc.kcyc(1'b1, 1'b0, 19'h00010, 1'b1, w_a, 8'h00);
    rd(19'h00010, h0);
    idle(5);
    take(h0, 5, w_a);
    chk("drive after burst", oe, 0);
    mc.kcyc(1'b1, 1'b0, 19'h00010, 1'b1, w_b, 8'h36);
    idle(2);
    rd(19'h00010, h0);
    idle(5);
    take(h0, 5, merge(w_a, w_b, 8'h36));
  endtask : s_rw
  task automatic s_arb();
    mc.kcyc(1'b0, 1'b0, 19'h00010, 1'b0, '0, '0);
    h0 = mc.hc - 1;
    mc.kcyc(1'b0, 1'b0, 19'h00010, 1'b1, w_c, 8'h00);
    mc.kcyc(1'b0, 1'b0, 19'h00010, 1'b0, '0, '0);
    idle(5);
    take(h0, 5, merge(w_a, w_b, 8'h36));
    take(h0 + 4, 5, w_c);
  endtask : s_arb
  task automatic s_b2b();
    rd(19'h00010, h0);
    mc.kcyc(1'b0, 1'b1, 19'h00020, 1'b0, '0, '0);
    idle(5);
    take(h0, 5, w_c);
    chk("dropped read", rq.size(), 0);
    mc.kcyc(1'b1, 1'b0, 19'h00020, 1'b1, w_a, 8'h00);
    mc.kcyc(1'b1, 1'b0, 19'h00020, 1'b0, w_b, 8'h00);
    idle(3);
    rd(19'h00020, h0);
    idle(5);
    take(h0, 5, w_a);
  endtask : s_b2b
  task automatic s_legacy();
    @(posedge clk);
    loop_n <= 1'b0;
    #13;
    idle(2);
    rd(19'h00010, h0);
    idle(5);
    take(h0, 2, w_c);
    chk("lock in legacy", lk, 0);
    @(posedge clk);
    loop_n <= 1'b1;
  endtask : s_legacy
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #13;
    s_lock();
    s_rw();
    s_arb();
    s_b2b();
    s_legacy();
    close_out();
  end
endmodule : testbench
